// [logic/csw_control_regs.sv]
/*
  csw_control_regs: control bytes 8 to 13 of the clock synthesizer: request
  gating of differential pairs 4..7, dynamic CPU multipliers, smooth switch
  and watchdog. Assumes the serial management host has already decoded its
  transfer into byte reads and writes on the register port.
*/
//
// What this block does
// - pin b stops pairs 5, 4 when gated
// - frequency code 01/10/11 picks multiplier one/two/three
// - multipliers nine bits, msb in shared byte
// - bypass bit, one at reset, disables smooth switch
// - select bit steers smooth switch CPU or peripheral
// - recovery source: hardware straps or programmed multiplier
// - timeout pulses reset; action bit picks reload
// - time base 294 ms or 2.34 s, reset one
// - alarm set on timeout, cleared with multiple field
// - timeout equals multiple times base; 000 test
// - enable starts watchdog loading multiple; clear stops
// - autorecovery bit selects automatic or manual recovery
// - dynamic multipliers apply only when enabled
`default_nettype none

module csw_control_regs #(
  parameter int SHORT_BASE_CYCLES = csw_pkg::SHORT_BASE_CYCLES,
  parameter int LONG_BASE_CYCLES  = csw_pkg::LONG_BASE_CYCLES
) (
  input  wire logic       clk,                         // 20 MHz system clock
  input  wire logic       rst_n,                       // synchronous reset, active low
  input  wire logic [7:0] reg_addr,                    // byte offset
  input  wire logic       reg_wr_en,                   // byte write strobe
  input  wire logic [7:0] reg_wr_data,                 // byte write data
  input  wire logic       reg_rd_en,                   // byte read strobe
  output var  logic [7:0] reg_rd_data,                 // read data, valid cycle after strobe
  input  wire logic       clock_request_pin_a_n,       // first request pin, low requests clock
  input  wire logic       clock_request_pin_b_n,       // second request pin, low requests clock
  output var  logic [3:0] pair_clock_enable,           // pairs 7..4 running
  input  wire logic [1:0] dyn_freq_code,               // dynamic frequency code
  input  wire logic       dyn_freq_enable,             // dynamic frequency enable
  output var  logic       dyn_mult_active,             // a stored multiplier is applied
  output var  logic [8:0] dyn_mult_applied,            // applied multiplier
  output var  logic       smooth_switch_active,        // gradual transition logic on
  output var  logic       smooth_switch_pll_select,    // 0 cpu pll, 1 periph reference pll
  input  wire logic       autorecovery_mode,           // 1 automatic, 0 manual recovery
  output var  logic       recovery_use_programmed,     // reboot uses programmed multiplier
  output var  logic       recovery_reload,             // pulse: reload recovery frequency
  output var  logic       recovery_pending,            // manual recovery awaits host
  output var  logic       system_reset_out_n           // system reset, active low
);

  logic [3:0] gate_q;
  logic [3:0] gate_d;
  logic [8:0] mult_one_q;
  logic [8:0] mult_one_d;
  logic [8:0] mult_two_q;
  logic [8:0] mult_two_d;
  logic [8:0] mult_three_q;
  logic [8:0] mult_three_d;
  logic       bypass_q;
  logic       bypass_d;
  logic       pll_sel_q;
  logic       pll_sel_d;
  logic       rec_src_q;
  logic       rec_src_d;
  logic       action_q;
  logic       action_d;
  logic       scale_q;
  logic       scale_d;
  logic       alarm_q;
  logic       alarm_d;
  logic [2:0] multiple_q;
  logic [2:0] multiple_d;
  logic       wdog_on_q;
  logic       wdog_on_d;
  logic [7:0] rd_data_q;
  logic [7:0] rd_data_d;
  logic [3:0] pair_en_q;
  logic [3:0] pair_en_d;
  logic       mult_active_q;
  logic       mult_active_d;
  logic [8:0] mult_applied_q;
  logic [8:0] mult_applied_d;
  logic [3:0] rst_cnt_q;
  logic [3:0] rst_cnt_d;
  logic       reload_q;
  logic       reload_d;
  logic       pending_q;
  logic       pending_d;

  logic       wr_wd;
  logic       wd_load;
  logic       tick_short;
  logic       tick_long;
  logic       base_tick;
  logic       timeout;

  assign wr_wd   = reg_wr_en && (reg_addr == csw_pkg::OFF_WATCHDOG_CONTROL);
  assign wd_load = wr_wd && reg_wr_data[csw_pkg::BIT_WATCHDOG_ENABLE];
  assign base_tick = scale_q ? tick_long : tick_short;

  csw_tick_divider #(
    .PERIOD (SHORT_BASE_CYCLES)
  ) u_div_short (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (wd_load),
    .tick  (tick_short)
  );

  csw_tick_divider #(
    .PERIOD (LONG_BASE_CYCLES)
  ) u_div_long (
    .clk   (clk),
    .rst_n (rst_n),
    .clear (wd_load),
    .tick  (tick_long)
  );

  csw_watchdog u_watchdog (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (wd_load),
    .enable   (wdog_on_d),
    .multiple (wr_wd ? reg_wr_data[csw_pkg::BIT_TIMEOUT_MULTIPLE_HI:csw_pkg::BIT_TIMEOUT_MULTIPLE_LO]
                     : multiple_q),
    .tick     (base_tick),
    .timeout  (timeout)
  );

  // register writes
  always_comb begin
    gate_d       = gate_q;
    mult_one_d   = mult_one_q;
    mult_two_d   = mult_two_q;
    mult_three_d = mult_three_q;
    bypass_d     = bypass_q;
    pll_sel_d    = pll_sel_q;
    rec_src_d    = rec_src_q;
    action_d     = action_q;
    scale_d      = scale_q;
    multiple_d   = multiple_q;
    wdog_on_d    = wdog_on_q;
    alarm_d      = alarm_q;
    if (reg_wr_en) begin
      case (reg_addr)
        csw_pkg::OFF_CLOCK_REQUEST_GATING: begin
          gate_d = reg_wr_data[csw_pkg::BIT_PAIR7_REQUEST_GATE:csw_pkg::BIT_PAIR4_REQUEST_GATE];
        end
        csw_pkg::OFF_DYN_FREQ_MSB_SMOOTH_SWITCH: begin
          mult_one_d[8]   = reg_wr_data[csw_pkg::BIT_DYN_MULT_ONE_MSB];
          mult_two_d[8]   = reg_wr_data[csw_pkg::BIT_DYN_MULT_TWO_MSB];
          mult_three_d[8] = reg_wr_data[csw_pkg::BIT_DYN_MULT_THREE_MSB];
          bypass_d        = reg_wr_data[csw_pkg::BIT_SMOOTH_SWITCH_BYPASS];
          pll_sel_d       = reg_wr_data[csw_pkg::BIT_SMOOTH_SWITCH_PLL_SEL];
        end
        csw_pkg::OFF_DYN_FREQ_ONE_LOW: begin
          mult_one_d[7:0] = reg_wr_data;
        end
        csw_pkg::OFF_DYN_FREQ_TWO_LOW: begin
          mult_two_d[7:0] = reg_wr_data;
        end
        csw_pkg::OFF_DYN_FREQ_THREE_LOW: begin
          mult_three_d[7:0] = reg_wr_data;
        end
        csw_pkg::OFF_WATCHDOG_CONTROL: begin
          rec_src_d  = reg_wr_data[csw_pkg::BIT_RECOVERY_SOURCE];
          action_d   = reg_wr_data[csw_pkg::BIT_TIMEOUT_ACTION];
          scale_d    = reg_wr_data[csw_pkg::BIT_TIME_SCALE];
          multiple_d = reg_wr_data[csw_pkg::BIT_TIMEOUT_MULTIPLE_HI:csw_pkg::BIT_TIMEOUT_MULTIPLE_LO];
          wdog_on_d  = reg_wr_data[csw_pkg::BIT_WATCHDOG_ENABLE];
          if (multiple_d == 3'h0) begin
            alarm_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // a timeout in the clearing cycle keeps the alarm
    if (timeout) begin
      alarm_d = 1'b1;
    end
  end

  // read path; reserved bits read zero
  always_comb begin
    rd_data_d = rd_data_q;
    if (reg_rd_en) begin
      case (reg_addr)
        csw_pkg::OFF_CLOCK_REQUEST_GATING:       rd_data_d = {gate_q, 4'h0};
        csw_pkg::OFF_DYN_FREQ_MSB_SMOOTH_SWITCH: rd_data_d = {mult_three_q[8], mult_two_q[8], mult_one_q[8],
                                                              2'h0, bypass_q, pll_sel_q, 1'b0};
        csw_pkg::OFF_DYN_FREQ_ONE_LOW:           rd_data_d = mult_one_q[7:0];
        csw_pkg::OFF_DYN_FREQ_TWO_LOW:           rd_data_d = mult_two_q[7:0];
        csw_pkg::OFF_DYN_FREQ_THREE_LOW:         rd_data_d = mult_three_q[7:0];
        csw_pkg::OFF_WATCHDOG_CONTROL:           rd_data_d = {rec_src_q, action_q, scale_q, alarm_q,
                                                              multiple_q, wdog_on_q};
        default:                                 rd_data_d = 8'h00;
      endcase
    end
  end

  // pair gating and multiplier selection
  always_comb begin
    pair_en_d[3] = !(gate_q[3] && clock_request_pin_a_n);
    pair_en_d[2] = !(gate_q[2] && clock_request_pin_a_n);
    pair_en_d[1] = !(gate_q[1] && clock_request_pin_b_n);
    pair_en_d[0] = !(gate_q[0] && clock_request_pin_b_n);
    mult_active_d  = dyn_freq_enable && (dyn_freq_code != 2'h0);
    mult_applied_d = mult_applied_q;
    case (dyn_freq_code)
      csw_pkg::CODE_DYN_ONE:   mult_applied_d = mult_one_q;
      csw_pkg::CODE_DYN_TWO:   mult_applied_d = mult_two_q;
      csw_pkg::CODE_DYN_THREE: mult_applied_d = mult_three_q;
      default:                 mult_applied_d = mult_applied_q;
    endcase
    if (!dyn_freq_enable) begin
      mult_applied_d = mult_applied_q;
    end
  end

  // timeout consequences
  always_comb begin
    rst_cnt_d = rst_cnt_q;
    reload_d  = 1'b0;
    pending_d = pending_q;
    if (timeout) begin
      rst_cnt_d = csw_pkg::RESET_PULSE_CYCLES;
      if (!action_q) begin
        if (autorecovery_mode) begin
          reload_d = 1'b1;
        end else begin
          pending_d = 1'b1;
        end
      end
    end else begin
      if (rst_cnt_q != 4'h0) begin
        rst_cnt_d = rst_cnt_q - 4'h1;
      end
      if (wr_wd) begin
        pending_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_q         <= csw_pkg::RST_REQUEST_GATES;
      mult_one_q     <= csw_pkg::RST_DYN_MULT;
      mult_two_q     <= csw_pkg::RST_DYN_MULT;
      mult_three_q   <= csw_pkg::RST_DYN_MULT;
      bypass_q       <= csw_pkg::RST_SMOOTH_SWITCH_BYPASS;
      pll_sel_q      <= csw_pkg::RST_SMOOTH_SWITCH_PLL_SEL;
      rec_src_q      <= csw_pkg::RST_RECOVERY_SOURCE;
      action_q       <= csw_pkg::RST_TIMEOUT_ACTION;
      scale_q        <= csw_pkg::RST_TIME_SCALE;
      alarm_q        <= 1'b0;
      multiple_q     <= csw_pkg::RST_TIMEOUT_MULTIPLE;
      wdog_on_q      <= csw_pkg::RST_WATCHDOG_ENABLE;
      rd_data_q      <= 8'h00;
      pair_en_q      <= 4'hf;
      mult_active_q  <= 1'b0;
      mult_applied_q <= csw_pkg::RST_DYN_MULT;
      rst_cnt_q      <= 4'h0;
      reload_q       <= 1'b0;
      pending_q      <= 1'b0;
    end else begin
      gate_q         <= gate_d;
      mult_one_q     <= mult_one_d;
      mult_two_q     <= mult_two_d;
      mult_three_q   <= mult_three_d;
      bypass_q       <= bypass_d;
      pll_sel_q      <= pll_sel_d;
      rec_src_q      <= rec_src_d;
      action_q       <= action_d;
      scale_q        <= scale_d;
      alarm_q        <= alarm_d;
      multiple_q     <= multiple_d;
      wdog_on_q      <= wdog_on_d;
      rd_data_q      <= rd_data_d;
      pair_en_q      <= pair_en_d;
      mult_active_q  <= mult_active_d;
      mult_applied_q <= mult_applied_d;
      rst_cnt_q      <= rst_cnt_d;
      reload_q       <= reload_d;
      pending_q      <= pending_d;
    end
  end

  assign reg_rd_data              = rd_data_q;
  assign pair_clock_enable        = pair_en_q;
  assign dyn_mult_active          = mult_active_q;
  assign dyn_mult_applied         = mult_applied_q;
  assign smooth_switch_active     = !bypass_q;
  assign smooth_switch_pll_select = pll_sel_q;
  assign recovery_use_programmed  = rec_src_q;
  assign recovery_reload          = reload_q;
  assign recovery_pending         = pending_q;
  assign system_reset_out_n       = (rst_cnt_q == 4'h0);

endmodule : csw_control_regs

`default_nettype wire

// [logic/csw_pkg.sv]
/*
  csw_pkg: offsets, field positions, reset values and timing counts for the
  clock synthesizer control bytes 8 to 13 and the watchdog.
  Assumes a 20 MHz system clock.
*/
`default_nettype none

package csw_pkg;

  // register offsets
  localparam logic [7:0] OFF_CLOCK_REQUEST_GATING      = 8'h08;
  localparam logic [7:0] OFF_DYN_FREQ_MSB_SMOOTH_SWITCH = 8'h09;
  localparam logic [7:0] OFF_DYN_FREQ_ONE_LOW          = 8'h0a;
  localparam logic [7:0] OFF_DYN_FREQ_TWO_LOW          = 8'h0b;
  localparam logic [7:0] OFF_DYN_FREQ_THREE_LOW        = 8'h0c;
  localparam logic [7:0] OFF_WATCHDOG_CONTROL          = 8'h0d;

  // clock_request_gating fields
  localparam int BIT_PAIR7_REQUEST_GATE = 7;
  localparam int BIT_PAIR6_REQUEST_GATE = 6;
  localparam int BIT_PAIR5_REQUEST_GATE = 5;
  localparam int BIT_PAIR4_REQUEST_GATE = 4;

  // dyn_freq_msb_smooth_switch fields
  localparam int BIT_DYN_MULT_THREE_MSB     = 7;
  localparam int BIT_DYN_MULT_TWO_MSB       = 6;
  localparam int BIT_DYN_MULT_ONE_MSB       = 5;
  localparam int BIT_SMOOTH_SWITCH_BYPASS   = 2;
  localparam int BIT_SMOOTH_SWITCH_PLL_SEL  = 1;

  // watchdog_control fields
  localparam int BIT_RECOVERY_SOURCE        = 7;
  localparam int BIT_TIMEOUT_ACTION         = 6;
  localparam int BIT_TIME_SCALE             = 5;
  localparam int BIT_WATCHDOG_ALARM_FLAG    = 4;
  localparam int BIT_TIMEOUT_MULTIPLE_HI    = 3;
  localparam int BIT_TIMEOUT_MULTIPLE_LO    = 1;
  localparam int BIT_WATCHDOG_ENABLE        = 0;

  // dynamic frequency codes
  localparam logic [1:0] CODE_DYN_ONE   = 2'h1;
  localparam logic [1:0] CODE_DYN_TWO   = 2'h2;
  localparam logic [1:0] CODE_DYN_THREE = 2'h3;

  // reset values
  localparam logic [3:0] RST_REQUEST_GATES        = 4'h0;
  localparam logic [8:0] RST_DYN_MULT             = 9'h000;
  localparam logic       RST_SMOOTH_SWITCH_BYPASS = 1'b1;
  localparam logic       RST_SMOOTH_SWITCH_PLL_SEL = 1'b0;
  localparam logic       RST_RECOVERY_SOURCE      = 1'b0;
  localparam logic       RST_TIMEOUT_ACTION       = 1'b0;
  localparam logic       RST_TIME_SCALE           = 1'b1;
  localparam logic [2:0] RST_TIMEOUT_MULTIPLE     = 3'h0;
  localparam logic       RST_WATCHDOG_ENABLE      = 1'b0;

  // timing
  localparam int  CLK_HZ              = 20_000_000;
  localparam real TIME_SCALE_SHORT_MS = 294.0;
  localparam real TIME_SCALE_LONG_S   = 2.34;
  localparam int  SHORT_BASE_CYCLES   = int'(TIME_SCALE_SHORT_MS * 1.0e-3 * CLK_HZ);
  localparam int  LONG_BASE_CYCLES    = int'(TIME_SCALE_LONG_S * CLK_HZ);
  localparam logic [3:0] RESET_PULSE_CYCLES = 4'h8;

endpackage : csw_pkg

`default_nettype wire

// [logic/csw_tick_divider.sv]
/*
  csw_tick_divider: free counter giving a one-cycle enable every PERIOD clocks.
  Assumes clear restarts the period from zero.
*/
`default_nettype none

module csw_tick_divider #(
  parameter int PERIOD = 16
) (
  input  wire logic clk,    // system clock
  input  wire logic rst_n,  // synchronous reset, active low
  input  wire logic clear,  // restart the period
  output var  logic tick    // one-cycle pulse per period
);

  logic [31:0] count_q;
  logic [31:0] count_d;

  always_comb begin
    tick    = (count_q == 32'(PERIOD - 1));
    count_d = (clear || tick) ? 32'h0000_0000 : count_q + 32'h0000_0001;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= 32'h0000_0000;
    end else begin
      count_q <= count_d;
    end
  end

endmodule : csw_tick_divider

`default_nettype wire

// [logic/csw_watchdog.sv]
/*
  csw_watchdog: counts time-base ticks down from the loaded multiple and
  pulses timeout once. Assumes tick is a one-cycle enable.
*/
`default_nettype none

module csw_watchdog (
  input  wire logic       clk,       // system clock
  input  wire logic       rst_n,     // synchronous reset, active low
  input  wire logic       load,      // arm with multiple
  input  wire logic       enable,    // watchdog enable level
  input  wire logic [2:0] multiple,  // ticks to expiry
  input  wire logic       tick,      // time-base enable
  output var  logic       timeout    // one-cycle expiry pulse
);

  logic [2:0] remain_q;
  logic [2:0] remain_d;
  logic       armed_q;
  logic       armed_d;

  always_comb begin
    remain_d = remain_q;
    armed_d  = armed_q;
    timeout  = 1'b0;
    if (!enable) begin
      armed_d = 1'b0;
    end else if (load) begin
      remain_d = multiple;
      armed_d  = 1'b1;
    end else if (armed_q && tick) begin
      // code 000 (test) expires on the first tick
      if (remain_q <= 3'h1) begin
        timeout = 1'b1;
        armed_d = 1'b0;
      end else begin
        remain_d = remain_q - 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remain_q <= 3'h0;
      armed_q  <= 1'b0;
    end else begin
      remain_q <= remain_d;
      armed_q  <= armed_d;
    end
  end

endmodule : csw_watchdog

`default_nettype wire

// [tb/csw_control_regs_asserts.sv]
/*
  csw_control_regs_asserts: port-level checker for csw_control_regs.
  Assumes it is bound into the top with the same base-period parameters.
*/
`default_nettype none

module csw_control_regs_asserts #(
  parameter int SHORT_BASE_CYCLES = 20,
  parameter int LONG_BASE_CYCLES  = 50
) (
  input wire logic       clk,                      // clock
  input wire logic       rst_n,                    // sync reset
  input wire logic [7:0] reg_addr,                 // offset
  input wire logic       reg_wr_en,                // write strobe
  input wire logic [7:0] reg_wr_data,              // write byte
  input wire logic       reg_rd_en,                // read strobe
  input wire logic [7:0] reg_rd_data,              // read byte
  input wire logic       clock_request_pin_a_n,    // pin a
  input wire logic       clock_request_pin_b_n,    // pin b
  input wire logic [3:0] pair_clock_enable,        // pairs 7..4
  input wire logic [1:0] dyn_freq_code,            // code
  input wire logic       dyn_freq_enable,          // enable
  input wire logic       dyn_mult_active,          // applied flag
  input wire logic [8:0] dyn_mult_applied,         // multiplier
  input wire logic       smooth_switch_active,     // smooth on
  input wire logic       smooth_switch_pll_select, // pll select
  input wire logic       autorecovery_mode,        // auto mode
  input wire logic       recovery_use_programmed,  // recovery src
  input wire logic       recovery_reload,          // reload pulse
  input wire logic       recovery_pending,         // manual wait
  input wire logic       system_reset_out_n        // reset out
);
  localparam int T_LO = SHORT_BASE_CYCLES - 1;
  localparam int T_HI = SHORT_BASE_CYCLES + 2;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_pin_b_runs;
    !$past(clock_request_pin_b_n) |-> pair_clock_enable[1:0] == 2'h3;
  endproperty
  a_pin_b_runs: assert property (p_pin_b_runs) else $error("pairs 5,4 stopped while requested");

  property p_pin_a_runs;
    !$past(clock_request_pin_a_n) |-> pair_clock_enable[3:2] == 2'h3;
  endproperty
  a_pin_a_runs: assert property (p_pin_a_runs) else $error("pairs 7,6 stopped while requested");

  property p_dyn_on;
    $past(rst_n) && $past(dyn_freq_enable) && $past(dyn_freq_code) != 2'h0 |-> dyn_mult_active;
  endproperty
  a_dyn_on: assert property (p_dyn_on) else $error("multiplier not applied");

  property p_dyn_off;
    !$past(dyn_freq_enable) |-> !dyn_mult_active && $stable(dyn_mult_applied);
  endproperty
  a_dyn_off: assert property (p_dyn_off) else $error("multiplier applied while disabled");

  property p_reset_state;
    $rose(rst_n) |-> !smooth_switch_active && system_reset_out_n && pair_clock_enable == 4'hf;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

  property p_pulse_width;
    $fell(system_reset_out_n) |-> !system_reset_out_n [*8] ##1 system_reset_out_n;
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("reset pulse width wrong");

  property p_reload;
    recovery_reload |-> autorecovery_mode && $fell(system_reset_out_n);
  endproperty
  a_reload: assert property (p_reload) else $error("reload without timeout");

  property p_pending;
    $rose(recovery_pending) |-> !autorecovery_mode && $fell(system_reset_out_n);
  endproperty
  a_pending: assert property (p_pending) else $error("pending without manual timeout");

  property p_short_timeout;
    reg_wr_en && reg_addr == 8'h0d && reg_wr_data[5:0] == 6'h03 |-> ##[T_LO:T_HI] $fell(system_reset_out_n);
  endproperty
  a_short_timeout: assert property (p_short_timeout) else $error("one-period timeout missed");

endmodule : csw_control_regs_asserts

`default_nettype wire

// [tb/csw_control_regs_tb.sv]
/*
  csw_control_regs_tb: random and corner-case bench for csw_control_regs.
  Assumes base periods shortened to 20 and 50 cycles.
*/
`default_nettype none

module csw_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SP = 20;
  localparam int LP = 50;
  logic       clk, rst_n, wr_en, rd_en, pin_a_n, pin_b_n, dyn_en, auto_m;
  logic       active, sm_act, sm_sel, use_prog, reload, pend, sys_rst_n, low_seen;
  logic [7:0] addr, wdata, rdata, d;
  logic [1:0] code;
  logic [3:0] pairs;
  logic [8:0] applied, last;
  logic [7:0] regs [8:13];
  int         fails, checked;

  csw_control_regs #(.SHORT_BASE_CYCLES(SP), .LONG_BASE_CYCLES(LP)) i_csw_control_regs (
    .clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr_en(wr_en), .reg_wr_data(wdata),
    .reg_rd_en(rd_en), .reg_rd_data(rdata), .clock_request_pin_a_n(pin_a_n),
    .clock_request_pin_b_n(pin_b_n), .pair_clock_enable(pairs), .dyn_freq_code(code),
    .dyn_freq_enable(dyn_en), .dyn_mult_active(active), .dyn_mult_applied(applied),
    .smooth_switch_active(sm_act), .smooth_switch_pll_select(sm_sel), .autorecovery_mode(auto_m),
    .recovery_use_programmed(use_prog), .recovery_reload(reload), .recovery_pending(pend),
    .system_reset_out_n(sys_rst_n));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask : rd

  function automatic logic [3:0] exp_pairs(input logic [3:0] g, input logic pa, input logic pb);
    return ~(g & {pa, pa, pb, pb});
  endfunction : exp_pairs

  // one watchdog expiry: count, pulse, recovery outputs, alarm set then cleared
  task automatic wd(input logic [7:0] v, input logic am, input int n_exp);
    int         n;
    logic [7:0] r;
    @(posedge clk);
    auto_m <= am;
    wr(8'h0d, v);
    n = 0;
    while (sys_rst_n !== 1'b0 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    chk(9'(n), 9'(n_exp));
    chk(reload, am && !v[6]);
    chk(pend, !am && !v[6]);
    n = 0;
    while (sys_rst_n === 1'b0 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    chk(9'(n), 9'h008);
    chk(use_prog, v[7]);
    rd(8'h0d, r);
    chk(r[7:1], {v[7:5], 1'b1, v[3:1]});
    wr(8'h0d, v & 8'he0);
    rd(8'h0d, r);
    chk(r, v & 8'he0);
    chk(pend, 1'b0);
  endtask : wd

  initial begin
    void'($urandom(10));
    {wr_en, rd_en, pin_a_n, pin_b_n, dyn_en, auto_m} = 6'h00;
    addr = 8'h00;
    wdata = 8'h00;
    code = 2'h0;
    last = 9'h000;
    regs = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h20};
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wait_cyc(1);
    chk(pairs, 4'hf);
    chk(sm_act, 1'b0);
    for (int a = 7; a < 15; a++) begin
      rd(8'(a), d);
      chk(d, (a > 7 && a < 14) ? regs[a] : 8'h00);
    end
    wr(8'h09, 8'hff);
    wait_cyc(1);
    chk({sm_act, sm_sel}, 2'h1);
    wr(8'h09, 8'h00);
    regs[9] = 8'h00;
    wait_cyc(1);
    chk({sm_act, sm_sel}, 2'h2);
    for (int i = 0; i < 30; i++) begin
      int a;
      a = 8 + $urandom_range(0, 4);
      d = 8'($urandom());
      wr(8'(a), d);
      regs[a] = d & (a == 8 ? 8'hf0 : a == 9 ? 8'he6 : 8'hff);
      rd(8'(a), d);
      chk(d, regs[a]);
    end
    for (int i = 0; i < 24; i++) begin
      logic [2:0] s;
      s = (i < 8) ? 3'(i) : 3'($urandom());
      @(posedge clk);
      dyn_en <= s[2];
      code  <= s[1:0];
      wait_cyc(2);
      if (s[2] && s[1:0] != 2'h0)
        last = {regs[9][4 + s[1:0]], regs[9 + s[1:0]]};
      chk(active, s[2] && s[1:0] != 2'h0);
      chk(applied, last);
    end
    for (int g = 0; g < 16; g++) begin
      wr(8'h08, 8'(g << 4));
      for (int p = 0; p < 4; p++) begin
        @(posedge clk);
        pin_a_n <= p[1];
        pin_b_n <= p[0];
        wait_cyc(2);
        chk(pairs, exp_pairs(4'(g), p[1], p[0]));
      end
    end
    wd(8'h81, 1'b0, SP);
    wd(8'h23, 1'b1, LP);
    for (int i = 0; i < 4; i++) begin
      int m;
      m = $urandom_range(1, 7);
      d = {1'($urandom()), 1'($urandom()), 2'h0, 3'(m), 1'b1};
      wd(d, 1'($urandom()), m * SP);
    end
    wr(8'h0d, 8'h05);
    wait_cyc(10);
    wd(8'h03, 1'b1, SP);
    wr(8'h0d, 8'h05);
    wait_cyc(10);
    wr(8'h0d, 8'h04);
    low_seen = 1'b0;
    repeat (3 * SP) begin
      wait_cyc(1);
      if (sys_rst_n !== 1'b1)
        low_seen = 1'b1;
    end
    chk(low_seen, 1'b0);
    test_done();
  end

  initial begin
    #(20000 * 50);
    fails++;
    test_done();
  end

endmodule : csw_control_regs_tb

bind csw_control_regs csw_control_regs_asserts #(
  .SHORT_BASE_CYCLES(SHORT_BASE_CYCLES), .LONG_BASE_CYCLES(LONG_BASE_CYCLES)
) i_csw_control_regs_asserts (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .clock_request_pin_a_n(clock_request_pin_a_n),
  .clock_request_pin_b_n(clock_request_pin_b_n), .pair_clock_enable(pair_clock_enable),
  .dyn_freq_code(dyn_freq_code), .dyn_freq_enable(dyn_freq_enable), .dyn_mult_active(dyn_mult_active),
  .dyn_mult_applied(dyn_mult_applied), .smooth_switch_active(smooth_switch_active),
  .smooth_switch_pll_select(smooth_switch_pll_select), .autorecovery_mode(autorecovery_mode),
  .recovery_use_programmed(recovery_use_programmed), .recovery_reload(recovery_reload),
  .recovery_pending(recovery_pending), .system_reset_out_n(system_reset_out_n));

`default_nettype wire
